/* File: include/epiu_pkg.sv */
package epiu_pkg;
  // counts of sources
  localparam int EPIU_NUM_EXT = 3;
  localparam int EPIU_NUM_GRP = 4;
  localparam int EPIU_GRP_W = 8;
  localparam int EPIU_SENSE_W = 2;
  // bus widths
  localparam int EPIU_ADDR_W = 8;
  localparam int EPIU_DATA_W = 8;
  // data-space offsets of the registers
  localparam logic [7:0] EPIU_OFS_PC_FLAGS = 8'h3b;
  localparam logic [7:0] EPIU_OFS_EXT_FLAGS = 8'h3c;
  localparam logic [7:0] EPIU_OFS_EXT_ENABLES = 8'h3d;
  localparam logic [7:0] EPIU_OFS_PC_CONTROL = 8'h68;
  localparam logic [7:0] EPIU_OFS_SENSE = 8'h69;
  localparam logic [7:0] EPIU_OFS_PC_MASK0 = 8'h6b;
  localparam logic [7:0] EPIU_OFS_PC_MASK1 = 8'h6c;
  localparam logic [7:0] EPIU_OFS_PC_MASK2 = 8'h6d;
  localparam logic [7:0] EPIU_OFS_PC_MASK3 = 8'h73;
  // short i/o addresses sit this far below the data-space offset
  localparam logic [7:0] EPIU_IO_BASE = 8'h20;
  // short i/o addresses reach only below this bound
  localparam logic [7:0] EPIU_IO_TOP = 8'h40;
  // reset values
  localparam logic [7:0] EPIU_RST_REG = 8'h00;
  // sense-control codes
  localparam logic [1:0] EPIU_SENSE_LOW = 2'h0;
  localparam logic [1:0] EPIU_SENSE_ANY = 2'h1;
  localparam logic [1:0] EPIU_SENSE_FALL = 2'h2;
  localparam logic [1:0] EPIU_SENSE_RISE = 2'h3;
endpackage : epiu_pkg

/* File: core/epiu_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser, one lane per bit
module epiu_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q; // first stage, read only by the second
  logic [W-1:0] sync_q; // second stage

  // both stages reset low so no event is seen at release
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule : epiu_sync
`default_nettype wire

/* File: core/epiu_core.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - pins trigger even when driven as outputs
// - one request per group on enabled toggle
// - four masks pick contributing inputs per group
// - pin-change detection needs no clock
// - pin edges detected only while clocked
// - low level on pin detected without clock
// - level mode requests while pin stays low
// - level request needs low held through start-up
// - sense codes low, any, falling, rising
// - sense fields at bits 5:4, 3:2, 1:0
// - pins sampled into register, then compared
// - pulses over one clock are caught
// - pin request needs enable and global enable
// - registers at data offsets; those below 0x60 also at io minus 0x20
// - edge sets flag; level mode flag reads zero
// - flag cleared on vector entry or write one
// - group flag set on enabled input change
// - group request needs group, global enables, mask
module epiu_core
  import epiu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // pin levels, taken after the pad so own port drive is seen too
  input wire logic [epiu_pkg::EPIU_NUM_EXT-1:0] ext_irq_pin_i,
  input wire logic [epiu_pkg::EPIU_NUM_GRP*epiu_pkg::EPIU_GRP_W-1:0] pin_change_input_i,
  // global enable from the core status register
  input wire logic global_irq_enable_i,
  // vector-entry acknowledges, one cycle each
  input wire logic [epiu_pkg::EPIU_NUM_EXT-1:0] ext_irq_ack_i,
  input wire logic [epiu_pkg::EPIU_NUM_GRP-1:0] pin_change_ack_i,
  // register port
  input wire logic [epiu_pkg::EPIU_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_io_space_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [epiu_pkg::EPIU_DATA_W-1:0] reg_wdata_i,
  output logic [epiu_pkg::EPIU_DATA_W-1:0] reg_rdata_o,
  // requests toward the core
  output logic [epiu_pkg::EPIU_NUM_EXT-1:0] ext_irq_req_o,
  output logic [epiu_pkg::EPIU_NUM_GRP-1:0] pin_change_req_o,
  // clockless wake indication for the sleep controller
  output logic async_wake_o
);
  import epiu_pkg::*;

  localparam int NPC = EPIU_NUM_GRP * EPIU_GRP_W;

  // software-visible state
  logic [EPIU_NUM_EXT-1:0] ext_enables_q;
  logic [EPIU_SENSE_W*EPIU_NUM_EXT-1:0] sense_q;
  logic [EPIU_NUM_EXT-1:0] ext_flags_q;
  logic [EPIU_NUM_EXT-1:0] ext_flags_d;
  logic [EPIU_NUM_GRP-1:0] pc_control_q;
  logic [EPIU_NUM_GRP-1:0] pc_flags_q;
  logic [EPIU_NUM_GRP-1:0] pc_flags_d;
  logic [NPC-1:0] pc_mask_q;
  logic [EPIU_DATA_W-1:0] rdata_q;

  // synchronised pins and their previous samples
  logic [EPIU_NUM_EXT-1:0] ext_sync;
  logic [EPIU_NUM_EXT-1:0] ext_prev_q;
  logic [NPC-1:0] pc_sync;
  logic [NPC-1:0] pc_prev_q;

  // all pins pass two flops before any clocked logic reads them
  epiu_sync #(.W(EPIU_NUM_EXT + NPC)) u_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .async_i({ext_irq_pin_i, pin_change_input_i}),
    .sync_o({ext_sync, pc_sync})
  );

  // address decode: io addresses sit 0x20 below data offsets
  logic [EPIU_ADDR_W-1:0] eff_addr;
  // the sum wraps on purpose; out-of-window io addresses are refused below
  assign eff_addr = reg_io_space_i ? EPIU_ADDR_W'(reg_addr_i + EPIU_IO_BASE) : reg_addr_i;
  // extended registers are not reachable through the short io window
  wire addr_ok = !reg_io_space_i || (reg_addr_i < EPIU_IO_TOP);
  wire sel_ext_flags = addr_ok && (eff_addr == EPIU_OFS_EXT_FLAGS);
  wire sel_ext_en = addr_ok && (eff_addr == EPIU_OFS_EXT_ENABLES);
  wire sel_sense = addr_ok && (eff_addr == EPIU_OFS_SENSE);
  wire sel_pc_flags = addr_ok && (eff_addr == EPIU_OFS_PC_FLAGS);
  wire sel_pc_ctrl = addr_ok && (eff_addr == EPIU_OFS_PC_CONTROL);
  wire [EPIU_NUM_GRP-1:0] sel_mask = {EPIU_NUM_GRP{addr_ok}} &
                                     {eff_addr == EPIU_OFS_PC_MASK3,
                                      eff_addr == EPIU_OFS_PC_MASK2,
                                      eff_addr == EPIU_OFS_PC_MASK1,
                                      eff_addr == EPIU_OFS_PC_MASK0};

  // write-one-to-clear strobes
  wire [EPIU_NUM_EXT-1:0] ext_w1c = (reg_wr_i && sel_ext_flags) ?
                                    reg_wdata_i[EPIU_NUM_EXT-1:0] : '0;
  wire [EPIU_NUM_GRP-1:0] pc_w1c = (reg_wr_i && sel_pc_flags) ?
                                   reg_wdata_i[EPIU_NUM_GRP-1:0] : '0;

  // per-pin sense and flag logic
  logic [EPIU_NUM_EXT-1:0] ext_level_mode;
  logic [EPIU_NUM_EXT-1:0] ext_event;
  genvar gi;
  generate
    for (gi = 0; gi < EPIU_NUM_EXT; gi++)
    begin : g_ext
      // field of pin n at bits 2n+1:2n
      wire [EPIU_SENSE_W-1:0] sense = sense_q[gi*EPIU_SENSE_W +: EPIU_SENSE_W];
      // edges come from comparing the registered samples
      wire rise = ext_sync[gi] & ~ext_prev_q[gi];
      wire fall = ~ext_sync[gi] & ext_prev_q[gi];
      assign ext_level_mode[gi] = (sense == EPIU_SENSE_LOW);
      // decode of the trigger selection
      assign ext_event[gi] = (sense == EPIU_SENSE_ANY) ? (rise | fall) :
                             (sense == EPIU_SENSE_FALL) ? fall :
                             (sense == EPIU_SENSE_RISE) ? rise : 1'b0;
      // level mode keeps the flag clear; otherwise set wins over clear
      assign ext_flags_d[gi] = ext_level_mode[gi] ? 1'b0 :
                               ext_event[gi] ? 1'b1 :
                               (ext_w1c[gi] | ext_irq_ack_i[gi]) ? 1'b0 : ext_flags_q[gi];
      // level request lasts while the pin is low
      wire pending = ext_level_mode[gi] ? ~ext_sync[gi] : ext_flags_q[gi];
      // gated by own enable and the global enable
      assign ext_irq_req_o[gi] = pending & ext_enables_q[gi] & global_irq_enable_i;
    end
  endgenerate

  // per-group pin-change logic
  logic [EPIU_NUM_GRP-1:0] pc_event;
  logic [EPIU_NUM_GRP-1:0] pc_async_hit;
  generate
    for (gi = 0; gi < EPIU_NUM_GRP; gi++)
    begin : g_grp
      wire [EPIU_GRP_W-1:0] msk = pc_mask_q[gi*EPIU_GRP_W +: EPIU_GRP_W];
      // toggle on any masked input of the group
      wire [EPIU_GRP_W-1:0] tog = pc_sync[gi*EPIU_GRP_W +: EPIU_GRP_W] ^
                                  pc_prev_q[gi*EPIU_GRP_W +: EPIU_GRP_W];
      assign pc_event[gi] = |(tog & msk);
      // clockless compare of raw pins against the last known level
      assign pc_async_hit[gi] = pc_control_q[gi] &
        (|(msk & (pin_change_input_i[gi*EPIU_GRP_W +: EPIU_GRP_W] ^
                  pc_prev_q[gi*EPIU_GRP_W +: EPIU_GRP_W])));
      // set wins over ack or write-one clear
      assign pc_flags_d[gi] = pc_event[gi] ? 1'b1 :
                              (pc_w1c[gi] | pin_change_ack_i[gi]) ? 1'b0 : pc_flags_q[gi];
      assign pin_change_req_o[gi] = pc_flags_q[gi] & pc_control_q[gi] &
                                    global_irq_enable_i;
    end
  endgenerate

  // wake needs no clock: raw low level on a level-mode pin or a raw pin change.
  // a level released before start-up ends wakes the part but leaves no request,
  // since the clocked request path then sees the pin high
  assign async_wake_o = (|(ext_enables_q & ext_level_mode & ~ext_irq_pin_i)) |
                        (|pc_async_hit);

  // read mux; unused bits and unmapped addresses read zero
  logic [EPIU_DATA_W-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    for (int g = 0; g < EPIU_NUM_GRP; g++)
    begin
      if (sel_mask[g])
      begin
        rd_mux = pc_mask_q[g*EPIU_GRP_W +: EPIU_GRP_W];
      end
    end
    if (sel_ext_flags)
      rd_mux[EPIU_NUM_EXT-1:0] = ext_flags_q;
    if (sel_ext_en)
      rd_mux[EPIU_NUM_EXT-1:0] = ext_enables_q;
    if (sel_sense)
      rd_mux[EPIU_SENSE_W*EPIU_NUM_EXT-1:0] = sense_q;
    if (sel_pc_flags)
      rd_mux[EPIU_NUM_GRP-1:0] = pc_flags_q;
    if (sel_pc_ctrl)
      rd_mux[EPIU_NUM_GRP-1:0] = pc_control_q;
  end

  // sample history and flags; everything resets to zero
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ext_prev_q <= '0;
      pc_prev_q <= '0;
      ext_flags_q <= '0;
      pc_flags_q <= '0;
    end
    else
    begin
      ext_prev_q <= ext_sync;
      pc_prev_q <= pc_sync;
      ext_flags_q <= ext_flags_d;
      pc_flags_q <= pc_flags_d;
    end
  end

  // control registers written by software
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ext_enables_q <= EPIU_RST_REG[EPIU_NUM_EXT-1:0];
      sense_q <= EPIU_RST_REG[EPIU_SENSE_W*EPIU_NUM_EXT-1:0];
      pc_control_q <= EPIU_RST_REG[EPIU_NUM_GRP-1:0];
    end
    else if (reg_wr_i)
    begin
      if (sel_ext_en)
        ext_enables_q <= reg_wdata_i[EPIU_NUM_EXT-1:0];
      if (sel_sense)
        sense_q <= reg_wdata_i[EPIU_SENSE_W*EPIU_NUM_EXT-1:0];
      if (sel_pc_ctrl)
        pc_control_q <= reg_wdata_i[EPIU_NUM_GRP-1:0];
    end
  end

  // mask registers, one per group
  generate
    for (gi = 0; gi < EPIU_NUM_GRP; gi++)
    begin : g_mask
      always_ff @(posedge mclk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          pc_mask_q[gi*EPIU_GRP_W +: EPIU_GRP_W] <= EPIU_RST_REG;
        else if (reg_wr_i && sel_mask[gi])
          pc_mask_q[gi*EPIU_GRP_W +: EPIU_GRP_W] <= reg_wdata_i;
      end
    end
  endgenerate

  // read data is registered: valid the cycle after the read strobe
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_q <= '0;
    else if (reg_rd_i)
      rdata_q <= rd_mux;
  end

  assign reg_rdata_o = rdata_q;
endmodule : epiu_core
`default_nettype wire

/* File: verification/epiu_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// port-level checks on the pin interrupt unit
module epiu_assertions
  import epiu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic global_irq_enable_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_io_space_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [2:0] ext_irq_req_o,
  input wire logic [3:0] pin_change_req_o,
  input wire logic async_wake_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // a data-space read of one address
  sequence s_rd(logic [7:0] a);
    reg_rd_i && !reg_io_space_i && reg_addr_i == a;
  endsequence
  property p_ext_gie; ext_irq_req_o != 3'h0 |-> global_irq_enable_i; endproperty
  a_ext_gie: assert property (p_ext_gie) else $error("pin request without global enable");
  property p_pc_gie; pin_change_req_o != 4'h0 |-> global_irq_enable_i; endproperty
  a_pc_gie: assert property (p_pc_gie) else $error("group request without global enable");
  // nothing requested or woken as reset lets go
  property p_rst;
    $rose(arst_n_i) |-> {ext_irq_req_o, pin_change_req_o, reg_rdata_o, async_wake_o} == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_sense_rsv; s_rd(EPIU_OFS_SENSE) |=> reg_rdata_o[7:6] == 2'h0; endproperty
  a_sense_rsv: assert property (p_sense_rsv) else $error("unused sense bits set");
  property p_en_rsv; s_rd(EPIU_OFS_EXT_ENABLES) |=> reg_rdata_o[7:3] == 5'h00; endproperty
  a_en_rsv: assert property (p_en_rsv) else $error("unused enable bits set");
  property p_flag_rsv; s_rd(EPIU_OFS_EXT_FLAGS) |=> reg_rdata_o[7:3] == 5'h00; endproperty
  a_flag_rsv: assert property (p_flag_rsv) else $error("unused flag bits set");
  property p_unmapped; s_rd(8'h00) |=> reg_rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // read data only moves on a read
  property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
endmodule : epiu_assertions
bind epiu_core epiu_assertions chk_u (.mclk_i, .arst_n_i, .global_irq_enable_i, .reg_addr_i,
  .reg_io_space_i, .reg_rd_i, .reg_rdata_o, .ext_irq_req_o, .pin_change_req_o, .async_wake_o);
`default_nettype wire

/* File: verification/epiu_src.sv */
`timescale 1ns/10ps
`default_nettype none
// external sources on the pins; a level holds from edge to edge
module epiu_src
(
  input wire logic mclk_i,
  input wire logic [2:0] ext_set_i,
  input wire logic [31:0] pc_set_i,
  output logic [2:0] ext_pin_o,
  output logic [31:0] pc_pin_o
);
  // the flop keeps every pulse and low level a full clock or longer
  always_ff @(posedge mclk_i)
  begin
    ext_pin_o <= ext_set_i;
    pc_pin_o <= pc_set_i;
  end
endmodule : epiu_src
`default_nettype wire

/* File: verification/external_pin_interrupt_unit_test.sv */
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the pin interrupt unit
module external_pin_interrupt_unit_test;
  import epiu_pkg::*;
  logic mclk_i = 1'b0, arst_n_i = 1'b0, gie = 1'b0, io = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] eack = 3'h0, eset = 3'h0, epin, ereq;
  logic [3:0] pack = 4'h0, preq;
  logic [31:0] pset = 32'h0000_0000, ppin;
  logic wake;
  int num_errors = 0, comparisons = 0;
  always #10 mclk_i = ~mclk_i;
  epiu_src src_u (.mclk_i(mclk_i), .ext_set_i(eset), .pc_set_i(pset), .ext_pin_o(epin),
    .pc_pin_o(ppin));
  epiu_core dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ext_irq_pin_i(epin),
    .pin_change_input_i(ppin), .global_irq_enable_i(gie), .ext_irq_ack_i(eack),
    .pin_change_ack_i(pack), .reg_addr_i(addr), .reg_io_space_i(io), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .ext_irq_req_o(ereq),
    .pin_change_req_o(preq), .async_wake_o(wake));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic sp);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    io <= sp;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : wr_reg
  // read strobe, data lands one edge after it is taken
  task automatic rchk(input logic [7:0] a, input logic sp, input logic [7:0] exp);
    @(posedge mclk_i);
    addr <= a;
    io <= sp;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(posedge mclk_i);
    chk(rdata, exp);
  endtask : rchk
  task automatic t_regs;
    rchk(EPIU_OFS_EXT_FLAGS, 1'b0, 8'h00);
    rchk(EPIU_OFS_EXT_ENABLES, 1'b0, 8'h00);
    rchk(EPIU_OFS_SENSE, 1'b0, 8'h00);
    wr_reg(8'h00, 8'hff, 1'b0);
    rchk(8'h00, 1'b0, 8'h00);
    wr_reg(EPIU_OFS_SENSE, 8'hff, 1'b0);
    rchk(EPIU_OFS_SENSE, 1'b0, 8'h3f);
    wr_reg(EPIU_OFS_SENSE - EPIU_IO_BASE, 8'h00, 1'b1);
    rchk(EPIU_OFS_SENSE, 1'b0, 8'h3f);
    wr_reg(EPIU_OFS_PC_MASK3, 8'ha5, 1'b0);
    rchk(EPIU_OFS_PC_MASK3, 1'b0, 8'ha5);
    wr_reg(EPIU_OFS_EXT_ENABLES - EPIU_IO_BASE, 8'hff, 1'b1);
    rchk(EPIU_OFS_EXT_ENABLES, 1'b0, 8'h07);
    $display("t_regs done");
  endtask : t_regs
  // move pin n, expect its flag, gate by global enable, then clear
  task automatic half(input int n, input logic lvl, input logic exp, input logic by_ack);
    @(posedge mclk_i);
    eset[n] <= lvl;
    repeat (6) @(posedge mclk_i);
    rchk(EPIU_OFS_EXT_FLAGS, 1'b0, {7'h00, exp} << n);
    chk({5'h00, ereq}, 8'h00);
    gie <= 1'b1;
    @(posedge mclk_i);
    chk({5'h00, ereq}, {7'h00, exp} << n);
    if (by_ack)
      eack <= 3'h1 << n;
    else
      wr_reg(EPIU_OFS_EXT_FLAGS, 8'h07, 1'b0);
    @(posedge mclk_i);
    eack <= 3'h0;
    gie <= 1'b0;
    rchk(EPIU_OFS_EXT_FLAGS, 1'b0, 8'h00);
  endtask : half
  task automatic t_edge;
    logic [1:0] code [3] = '{EPIU_SENSE_RISE, EPIU_SENSE_FALL, EPIU_SENSE_ANY};
    for (int n = 0; n < 3; n++)
    begin
      wr_reg(EPIU_OFS_SENSE, {6'h00, code[n]} << (2 * n), 1'b0);
      wr_reg(EPIU_OFS_EXT_ENABLES, 8'h01 << n, 1'b0);
      half(n, 1'b1, code[n] != EPIU_SENSE_FALL, 1'b1);
      half(n, 1'b0, code[n] != EPIU_SENSE_RISE, 1'b0);
    end
    $display("t_edge done");
  endtask : t_edge
  // low level on pin 2 requests while held and keeps the flag clear
  task automatic t_level;
    wr_reg(EPIU_OFS_SENSE, 8'h30, 1'b0);
    eset[2] <= 1'b1;
    repeat (6) @(posedge mclk_i);
    wr_reg(EPIU_OFS_SENSE, 8'h00, 1'b0);
    rchk(EPIU_OFS_EXT_FLAGS, 1'b0, 8'h00);
    gie <= 1'b1;
    eset[2] <= 1'b0;
    repeat (20) @(posedge mclk_i);
    chk({5'h00, ereq}, 8'h04);
    chk({7'h00, wake}, 8'h01);
    rchk(EPIU_OFS_EXT_FLAGS, 1'b0, 8'h00);
    chk({5'h00, ereq}, 8'h04);
    eset[2] <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk({5'h00, ereq}, 8'h00);
    chk({7'h00, wake}, 8'h00);
    $display("t_level done");
  endtask : t_level
  // group 1, only input 11 masked in
  task automatic t_pc;
    wr_reg(EPIU_OFS_PC_MASK1, 8'h08, 1'b0);
    wr_reg(EPIU_OFS_PC_CONTROL, 8'h02, 1'b0);
    pset[9] <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rchk(EPIU_OFS_PC_FLAGS, 1'b0, 8'h00);
    pset[11] <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk({7'h00, wake}, 8'h01);
    repeat (6) @(posedge mclk_i);
    rchk(EPIU_OFS_PC_FLAGS, 1'b0, 8'h02);
    chk({4'h0, preq}, 8'h02);
    wr_reg(EPIU_OFS_PC_CONTROL, 8'h00, 1'b0);
    // the write lands on the last edge of wr_reg; look one edge later once it has settled
    @(posedge mclk_i);
    chk({4'h0, preq}, 8'h00);
    wr_reg(EPIU_OFS_PC_FLAGS, 8'h02, 1'b0);
    rchk(EPIU_OFS_PC_FLAGS, 1'b0, 8'h00);
    // falling toggle sets the flag again; read via io window, clear by vector entry
    pset[11] <= 1'b0;
    repeat (6) @(posedge mclk_i);
    rchk(EPIU_OFS_PC_FLAGS - EPIU_IO_BASE, 1'b1, 8'h02);
    pack <= 4'h2;
    @(posedge mclk_i);
    pack <= 4'h0;
    rchk(EPIU_OFS_PC_FLAGS, 1'b0, 8'h00);
    $display("t_pc done");
  endtask : t_pc
  // the one place the run ends
  task automatic close_out;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (6) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_regs;
    t_edge;
    t_level;
    t_pc;
    close_out;
  end
  // watchdog, far beyond the few hundred cycles the tests take
  initial
  begin
    repeat (3000) @(posedge mclk_i);
    num_errors++;
    close_out;
  end
endmodule : external_pin_interrupt_unit_test
`default_nettype wire
